//--- core/pubs_boot_sequencer.v
`timescale 1ns/1ns
`include "pubs_defines.vh"

// Overview of operation
// R1 - Below the supply threshold the serial interface stays unavailable and silent.
// R2 - Boot starts by itself once the supply threshold is crossed.
// R3 - Boot initialises state and copies defaults from OTP into working settings.
// R4 - Normal strap: set boot-done flag, optionally emit one fixed-width boot pulse.
// R5 - Normal strap: pulse routable to either output, defaulting to output a.
// R6 - Motion strap: also load motion-detection defaults from OTP before boot done.
// R7 - Motion strap: boot done, pulse only on output b, never output a.
// R8 - Host waits for boot completion before any serial access.
module pubs_boot_sequencer #(
  parameter PULSE_NORMAL_CYC = `PUBS_PULSE_NORMAL_CYC,
  parameter PULSE_MOTION_CYC = `PUBS_PULSE_MOTION_CYC
) (
  input  wire        ref_clk_i,
  input  wire        arst_n_i,
  input  wire        supply_ok_i,
  input  wire        boot_strap_select_i,
  input  wire        pulse_enable_i,
  input  wire        pulse_route_b_i,
  output reg  [3:0]  otp_addr_o,
  output reg         otp_rd_o,
  input  wire [7:0]  otp_data_i,
  output reg  [63:0] cfg_settings_o,
  output reg  [31:0] motion_params_o,
  output reg         boot_done_flag_o,
  output reg         serial_avail_o,
  output reg         irq_output_a_o,
  output reg         irq_output_b_o,
  output reg         motion_mode_o
);

  // ==========================================================
  // Reset release and input synchronisers.
  reg rst_s1_r;
  reg rst_n_r;
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // The supply, strap and route pins are asynchronous to the clock, so each passes two flip-flops.
  // Only the second stage is read by the boot logic.
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {supply_ok_i, boot_strap_select_i, pulse_route_b_i};
      sync2_r <= sync1_r;
    end
  end
  wire supply_ok = sync2_r[2];
  wire strap_mot = sync2_r[1];
  wire route_b   = sync2_r[0];

  // ==========================================================
  // Helper functions.

  // Next word address or index; wraps within four bits.
  function [3:0] pubs_next_addr;
    input [3:0] addr;
    begin
      pubs_next_addr = addr + 4'h1;
    end
  endfunction

  // Boot pulse length in clock cycles for the given strap.
  function [15:0] pubs_pulse_len;
    input motion;
    begin
      if (motion) begin
        pubs_pulse_len = PULSE_MOTION_CYC[15:0];
      end else begin
        pubs_pulse_len = PULSE_NORMAL_CYC[15:0];
      end
    end
  endfunction

  // ==========================================================
  // Boot state machine.
  // Boot phases in the order in which they run.
  localparam [2:0] ST_OFF   = 3'h0;
  localparam [2:0] ST_INIT  = 3'h1;
  localparam [2:0] ST_CFG   = 3'h2;
  localparam [2:0] ST_MOT   = 3'h3;
  localparam [2:0] ST_PULSE = 3'h4;
  localparam [2:0] ST_DONE  = 3'h5;

  // The word index counts reads within one block of the one-time memory.
  // The pulse counter is loaded while the last block is read.
  // The route flag is fixed when the strap is latched.
  reg  [2:0]  state_r;
  reg  [3:0]  idx_r;
  reg  [15:0] cnt_r;
  reg         pulse_b_r;
  // The strap picks which of the two pulse widths applies.
  wire [15:0] pulse_len = pubs_pulse_len(strap_mot);

  // ==========================================================
  // Sequencer registers and outputs.

  always @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r          <= ST_OFF;
      idx_r            <= 4'h0;
      cnt_r            <= 16'h0;
      pulse_b_r        <= 1'b0;
      otp_addr_o       <= 4'h0;
      otp_rd_o         <= 1'b0;
      cfg_settings_o   <= 64'h0;
      motion_params_o  <= 32'h0;
      boot_done_flag_o <= 1'b0;
      serial_avail_o   <= 1'b0;
      irq_output_a_o   <= 1'b0;
      irq_output_b_o   <= 1'b0;
      motion_mode_o    <= 1'b0;
    end else if (!supply_ok) begin
      // A supply drop aborts any boot phase and silences the interface.
      // Counters are cleared so that the next boot starts clean.
      state_r          <= ST_OFF; // R1
      idx_r            <= 4'h0;
      cnt_r            <= 16'h0;
      serial_avail_o   <= 1'b0; // R1
      boot_done_flag_o <= 1'b0;
      otp_rd_o         <= 1'b0;
      irq_output_a_o   <= 1'b0;
      irq_output_b_o   <= 1'b0;
    end else begin
      // The read strobe is a single-cycle pulse unless a phase raises it again.
      otp_rd_o <= 1'b0;
      case (state_r)
        // Boot begins without any host command.
        ST_OFF: begin
          state_r <= ST_INIT; // R2
        end

        // Clear the working settings and latch the strap for the whole boot.
        // Motion mode forces the pulse onto output b.
        ST_INIT: begin
          cfg_settings_o  <= 64'h0; // R3
          motion_params_o <= 32'h0;
          motion_mode_o   <= strap_mot;
          // R5 R7
          pulse_b_r       <= strap_mot | route_b;
          idx_r           <= 4'h0;
          otp_addr_o      <= 4'h0;
          otp_rd_o        <= 1'b1;
          state_r         <= ST_CFG;
        end

        // Each word is valid at the edge after its strobe.
        // Bytes shift in from the top, so the first byte ends lowest.
        ST_CFG: begin
          cfg_settings_o <= {otp_data_i, cfg_settings_o[63:8]}; // R3
          if (idx_r == `PUBS_CFG_WORDS - 1) begin
            idx_r <= 4'h0;
            if (motion_mode_o) begin
              otp_addr_o <= `PUBS_MOT_BASE; // R6
              otp_rd_o   <= 1'b1;
              state_r    <= ST_MOT;
            end else begin
              state_r <= ST_PULSE;
            end
          end else begin
            idx_r      <= pubs_next_addr(idx_r);
            otp_addr_o <= pubs_next_addr(otp_addr_o);
            otp_rd_o   <= 1'b1;
          end
          cnt_r <= pulse_len;
        end

        // Motion parameters follow the configuration block.
        ST_MOT: begin
          motion_params_o <= {otp_data_i, motion_params_o[31:8]}; // R6
          if (idx_r == `PUBS_MOT_WORDS - 1) begin
            state_r <= ST_PULSE;
          end else begin
            idx_r      <= pubs_next_addr(idx_r);
            otp_addr_o <= pubs_next_addr(otp_addr_o);
            otp_rd_o   <= 1'b1;
          end
          cnt_r <= pulse_len;
        end

        // The flag rises with the first pulse cycle.
        // With the pulse disabled the phase ends at once.
        ST_PULSE: begin
          boot_done_flag_o <= 1'b1; // R4
          if (pulse_enable_i && cnt_r != 16'h0) begin
            irq_output_a_o <= ~pulse_b_r; // R5 R7
            irq_output_b_o <= pulse_b_r; // R4
            cnt_r          <= cnt_r - 16'h1;
          end else begin
            irq_output_a_o <= 1'b0;
            irq_output_b_o <= 1'b0;
            state_r        <= ST_DONE;
          end
        end

        // Boot is complete; the interface stays available until supply loss.
        ST_DONE: begin
          serial_avail_o <= 1'b1; // R8
        end

        // Unused codes fall back to the off phase.
        default: begin
          state_r <= ST_OFF;
        end
      endcase
    end
  end

endmodule

//--- common/pubs_defines.vh
`ifndef PUBS_DEFINES_VH
`define PUBS_DEFINES_VH

// Clock period in ns.
`define PUBS_CLK_PERIOD_NS      8
// Boot pulse widths in ns.
`define PUBS_PULSE_NORMAL_NS    20000
`define PUBS_PULSE_MOTION_NS    20000
`define PUBS_PULSE_NORMAL_CYC   (`PUBS_PULSE_NORMAL_NS / `PUBS_CLK_PERIOD_NS)
`define PUBS_PULSE_MOTION_CYC   (`PUBS_PULSE_MOTION_NS / `PUBS_CLK_PERIOD_NS)
// Word counts of default configuration and motion parameters.
`define PUBS_CFG_WORDS          8
`define PUBS_MOT_WORDS          4
`define PUBS_OTP_AW             4
`define PUBS_MOT_BASE           4'h8

`endif

//--- testbench/pubs_otp_model.sv
`timescale 1ns/1ns
module pubs_otp_model (
  input  wire       clk_i,
  input  wire       rd_i,
  input  wire [3:0] addr_i,
  output reg  [7:0] data_o
);
  initial data_o = 8'h00;
  // Word n reads as a0+n; between reads the bus toggles so stale data never passes.
  // The word is answered on the falling edge, so it is valid at the rising edge after the strobe.
  always @(negedge clk_i) data_o <= rd_i ? {4'ha, addr_i} : ~data_o;
endmodule

//--- testbench/pubs_boot_sequencer_properties.sv
`timescale 1ns/1ns
module pubs_boot_sequencer_properties #(
  parameter PULSE_NORMAL_CYC = 4,
  parameter PULSE_MOTION_CYC = 4
) (
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire supply_ok_i,
  input wire otp_rd_o,
  input wire boot_done_flag_o,
  input wire serial_avail_o,
  input wire irq_output_a_o,
  input wire irq_output_b_o,
  input wire motion_mode_o
);
  reg [15:0] hi_r;
  wire       irq_w = irq_output_a_o | irq_output_b_o;
  always @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i) hi_r <= 16'h0;
    else hi_r <= irq_w ? hi_r + 16'h1 : 16'h0;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_off_silent: assert property (!supply_ok_i [*4] |-> !serial_avail_o)
    else $error("serial available while off");
  a_boot_start: assert property ($rose(supply_ok_i) |-> ##[1:10] otp_rd_o)
    else $error("boot did not start");
  a_no_rd_done: assert property (boot_done_flag_o |-> !otp_rd_o)
    else $error("read after boot done");
  a_pulse_flag: assert property ($rose(irq_w) |-> ##[0:1] boot_done_flag_o)
    else $error("pulse without flag");
  a_pulse_width: assert property ($fell(irq_w) |->
    hi_r == (motion_mode_o ? PULSE_MOTION_CYC : PULSE_NORMAL_CYC))
    else $error("wrong pulse width");
  a_one_output: assert property (!(irq_output_a_o && irq_output_b_o))
    else $error("pulse on both outputs");
  a_motion_no_a: assert property (motion_mode_o |-> !irq_output_a_o)
    else $error("motion pulse on output a");
  a_avail_done: assert property (serial_avail_o |-> boot_done_flag_o && !irq_w)
    else $error("available before done");
  cover property ($rose(irq_output_a_o));
  cover property ($rose(irq_output_b_o) && motion_mode_o);
  cover property ($rose(serial_avail_o));
endmodule
bind pubs_boot_sequencer pubs_boot_sequencer_properties #(
  .PULSE_NORMAL_CYC(PULSE_NORMAL_CYC), .PULSE_MOTION_CYC(PULSE_MOTION_CYC)) u_props (.*);

//--- testbench/pubs_boot_sequencer_tb_top.sv
`timescale 1ns/1ns
module pubs_boot_sequencer_tb_top;
  reg         clk = 1'b0, rst_n = 1'b0, sup = 1'b0, strap = 1'b0, pen = 1'b0, rb = 1'b0;
  wire [3:0]  oa;
  wire [7:0]  od;
  wire [63:0] cfg;
  wire [31:0] mot;
  wire        ord, done, avail, ia, ib, mm;
  integer     err_count = 0;
  integer     checks = 0;
  always #4 clk = ~clk;
  pubs_otp_model u_pubs_otp_model (.clk_i(clk), .rd_i(ord), .addr_i(oa), .data_o(od));
  pubs_boot_sequencer #(.PULSE_NORMAL_CYC(4), .PULSE_MOTION_CYC(4)) u_pubs_boot_sequencer (
    .ref_clk_i(clk), .arst_n_i(rst_n), .supply_ok_i(sup), .boot_strap_select_i(strap),
    .pulse_enable_i(pen), .pulse_route_b_i(rb), .otp_addr_o(oa), .otp_rd_o(ord),
    .otp_data_i(od), .cfg_settings_o(cfg), .motion_params_o(mot), .boot_done_flag_o(done),
    .serial_avail_o(avail), .irq_output_a_o(ia), .irq_output_b_o(ib), .motion_mode_o(mm));
  task chk(input string n, input [63:0] e, input [63:0] s);
    begin
      checks = checks + 1;
      if (s !== e) begin
        $display("[FAIL] %s expected %h seen %h", n, e, s);
        err_count = err_count + 1;
      end
    end
  endtask
  task boot(input s, input e, input r, input ea, input eb);
    reg a, b;
    integer i;
    begin
      a = 1'b0;
      b = 1'b0;
      strap = s;
      pen = e;
      rb = r;
      sup = 1'b1;
      for (i = 0; i < 200 && avail !== 1'b1; i = i + 1) begin
        @(negedge clk);
        a = a | ia;
        b = b | ib;
      end
      chk("avail", 1, avail);
      chk("cfg", 64'ha7a6a5a4a3a2a1a0, cfg);
      if (s) chk("mot", 32'habaaa9a8, mot);
      else chk("mot", 0, mot);
      chk("mode", s, mm);
      chk("flag", 1, done);
      chk("irq", {ea, eb}, {a, b});
      sup = 1'b0;
      repeat (6) @(negedge clk);
      chk("off", 0, {avail, done});
      $display("boot test done");
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("idle", 0, {avail, done, ord});
    boot(0, 1, 0, 1, 0);
    boot(0, 1, 1, 0, 1);
    boot(1, 1, 0, 0, 1);
    boot(0, 0, 0, 0, 0);
    end_sim;
  end
  initial begin
    #100000;
    err_count = err_count + 1;
    end_sim;
  end
endmodule
